// ---- src/ppm_pkg.sv ----
// What this block does
// - Ports one-three direction selectable per bit; port zero bits 1-3 only
// - Software pull-up only on input-mode pins
// - Reset: ports 0-3,7,11,12 input; 8-10 output
// - Analog mode drops port one pull-ups
// - First interrupt: rising, falling or both edges
// - Fourth interrupt input reacts to falling edges
// - Port seven five-bit open-drain, per-bit direction
// - Ports eight to ten output-only, shared with display
// - Ports eleven, twelve open-drain, per-bit, display segments
// - Transfer strobe routed out on port two
// - Timer pin carries timer or PWM output
// - Three timer clock inputs from pins
// - Counter input pin clocks up/down counter
// - Display pins 0-15 digit/segment, rest segment
// - Serial lines separate or open-drain bus lines
`timescale 1ns/1ps
`default_nettype none

package ppm_pkg;
   localparam int NPORT = 13;
   localparam int PW    = 8;

   // ------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ------------------------------------------------------------
   localparam logic [1:0] RGN_DATA = 2'h0;   // 0x00 + 4*port
   localparam logic [1:0] RGN_MODE = 2'h1;   // 0x40 + 4*port, 1 = input
   localparam logic [1:0] RGN_PULL = 2'h2;   // 0x80 + 4*port
   localparam logic [1:0] RGN_CTRL = 2'h3;
   localparam logic [3:0] IDX_FUNC = 4'h0;   // 0xC0
   localparam logic [3:0] IDX_ALT  = 4'h1;   // 0xC4
   localparam logic [3:0] IDX_PCC  = 4'h2;   // 0xC8
   localparam logic [3:0] IDX_DISP = 4'h3;   // 0xCC

   // Function and clock control register fields
   localparam int FN_EDGE_A = 0;   // two bits each
   localparam int FN_EDGE_B = 2;
   localparam int FN_EDGE_C = 4;
   localparam int FN_PWM    = 6;
   localparam int FN_SBUS   = 7;
   localparam int FN_ADC    = 8;
   localparam int PCC_FRC   = 6;

   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;

   // Per-port masks, index = port number (4-6 absent)
   localparam logic [NPORT-1:0][PW-1:0] PORT_MASK = {
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h1F,
      8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
   localparam logic [NPORT-1:0][PW-1:0] MODE_MASK = {
      8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h1F,
      8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h0E};
   localparam logic [NPORT-1:0][PW-1:0] PULL_MASK = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h0E};
   localparam logic [NPORT-1:0][PW-1:0] FIXED_IN = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11};
   localparam int NCH_PORT   = 7;
   localparam int PCH_FIRST  = 8;
   localparam int DISP_PORTS = 5;

   typedef struct packed {
      logic [NPORT-1:0][PW-1:0] dat;
      logic [NPORT-1:0][PW-1:0] mode;
      logic [NPORT-1:0][PW-1:0] pu;
      logic [NPORT-1:0][PW-1:0] sync1;
      logic [NPORT-1:0][PW-1:0] sync2;
      logic [NPORT-1:0][PW-1:0] pad_out;
      logic [NPORT-1:0][PW-1:0] pad_oe_n;
      logic [NPORT-1:0][PW-1:0] pad_pu;
      logic [15:0]              func;
      logic [15:0]              alt;
      logic [7:0]               processor_clock_ctrl;
      logic [DISP_PORTS-1:0]    disp;
      logic                     ack;
      logic [31:0]              rdata;
   } ppm_state_t;

   typedef struct packed {
      logic prev;
      logic pulse;
   } ppm_edge_state_t;
endpackage

// ------------------------------------------------------------
// Edge detector on an already synchronised level
// ------------------------------------------------------------
module ppm_edge (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       level_i,
   input  wire logic [1:0] mode_i,
   output logic            pulse_o
);
   import ppm_pkg::*;
   ppm_edge_state_t st;
   ppm_edge_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.prev = level_i;
      case (mode_i)
         EDGE_RISE: next_st.pulse = level_i & ~st.prev;
         EDGE_FALL: next_st.pulse = ~level_i & st.prev;
         EDGE_BOTH: next_st.pulse = level_i ^ st.prev;
         default:   next_st.pulse = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // Track the idle level so release brings no false edge
         st <= '{prev: level_i, pulse: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign pulse_o = st.pulse;
endmodule

`default_nettype wire

// ---- src/ppm_port_mux.sv ----
`timescale 1ns/1ps
`default_nettype none

module ppm_port_mux #(
   parameter int ADR_W = 8
) (
   input  wire logic                                         clk_i,
   input  wire logic                                         rst_i,
   // Wishbone classic slave
   input  wire logic [ADR_W-1:0]                             wb_adr_i,
   input  wire logic [31:0]                                  wb_dat_i,
   input  wire logic [3:0]                                   wb_sel_i,
   input  wire logic                                         wb_we_i,
   input  wire logic                                         wb_cyc_i,
   input  wire logic                                         wb_stb_i,
   output logic      [31:0]                                  wb_dat_o,
   output logic                                              wb_ack_o,
   // Pads, index = port number
   input  wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0]   pad_in_i,
   output logic      [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0]   pad_out_o,
   output logic      [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0]   pad_oe_n_o,
   output logic      [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0]   pad_pu_o,
   // Peripheral outputs toward pins
   input  wire logic                                         ser_a_tx_i,
   input  wire logic                                         ser_a_clk_out_i,
   input  wire logic                                         ser_bus_line_a_i,
   input  wire logic                                         ser_bus_line_b_i,
   input  wire logic                                         ser_b_tx_i,
   input  wire logic                                         ser_b_clk_out_i,
   input  wire logic                                         auto_xfer_strobe_i,
   input  wire logic                                         wide_timer_out_i,
   input  wire logic                                         pwm_out_i,
   input  wire logic                                         narrow_timer_a_out_i,
   input  wire logic                                         narrow_timer_b_out_i,
   input  wire logic                                         prog_clock_out_i,
   input  wire logic                                         buzzer_out_i,
   input  wire logic [33:0]                                  display_drive_outputs_i,
   // Pin inputs and control bits toward peripherals
   output logic      [3:0]                                   ext_irq_o,
   output logic                                              wide_timer_ext_clk_o,
   output logic                                              narrow_timer_a_ext_clk_o,
   output logic                                              narrow_timer_b_ext_clk_o,
   output logic                                              updown_count_in_o,
   output logic                                              ser_a_rx_o,
   output logic                                              ser_bus_line_b_in_o,
   output logic                                              ser_a_clk_in_o,
   output logic                                              ser_b_rx_o,
   output logic                                              ser_b_clk_in_o,
   output logic                                              ser_busy_in_o,
   output logic                                              adc_select_o,
   output logic                                              osc_feedback_disable_o
);
   import ppm_pkg::*;

   if (ADR_W < 8) begin : g_chk
      $error("ADR_W must be at least 8");
   end

   ppm_state_t                st;
   ppm_state_t                next_st;
   logic [NPORT-1:0][PW-1:0]  dir_in;
   logic [1:0][PW-1:0]        alt_val;
   logic [NPORT-1:0][PW-1:0]  disp_val;
   logic [3:0]                irq_pulse;

   // ------------------------------------------------------------
   // Effective direction and alternate sources
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         dir_in[p] = (st.mode[p] & MODE_MASK[p]) | FIXED_IN[p];
      end
   end

   always_comb begin
      alt_val = '0;
      alt_val[0][1] = ser_b_tx_i;
      alt_val[0][2] = ser_b_clk_out_i;
      alt_val[0][3] = auto_xfer_strobe_i;
      alt_val[0][5] = ser_bus_line_a_i;
      alt_val[0][6] = st.func[FN_SBUS] ? ser_bus_line_b_i : ser_a_tx_i;
      alt_val[0][7] = ser_a_clk_out_i;
      alt_val[1][0] = st.func[FN_PWM] ? pwm_out_i : wide_timer_out_i;
      alt_val[1][1] = narrow_timer_a_out_i;
      alt_val[1][2] = narrow_timer_b_out_i;
      alt_val[1][5] = prog_clock_out_i;
      alt_val[1][6] = buzzer_out_i;
   end

   // Pins 0-15 may carry digits, the rest segments only; controller decides
   always_comb begin
      disp_val     = '0;
      disp_val[8]  = {6'h00, display_drive_outputs_i[1:0]};
      disp_val[9]  = display_drive_outputs_i[9:2];
      disp_val[10] = display_drive_outputs_i[17:10];
      disp_val[11] = display_drive_outputs_i[25:18];
      disp_val[12] = display_drive_outputs_i[33:26];
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [1:0] rgn;
      logic [3:0] idx;
      logic       val;
      logic       drv;
      logic       own;
      rgn = wb_adr_i[7:6];
      idx = wb_adr_i[5:2];
      val = 1'b0;
      drv = 1'b0;
      own = 1'b0;
      next_st = st;
      // Two stages before any reader; stage one feeds stage two only
      next_st.sync1 = pad_in_i;
      next_st.sync2 = st.sync1;
      next_st.ack = 1'b0;

      if (wb_cyc_i && wb_stb_i && !st.ack) begin
         next_st.ack = 1'b1;
         next_st.rdata = '0;
         if (rgn != RGN_CTRL && idx < 4'(NPORT)) begin
            case (rgn)
               RGN_DATA: begin
                  // Input bits read the pin, output bits read the latch
                  next_st.rdata[7:0] = ((st.sync2[idx] & dir_in[idx])
                                       | (st.dat[idx] & ~dir_in[idx])) & PORT_MASK[idx];
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.dat[idx] = wb_dat_i[7:0] & PORT_MASK[idx];
                  end
               end
               RGN_MODE: begin
                  next_st.rdata[7:0] = dir_in[idx] & PORT_MASK[idx];
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.mode[idx] = wb_dat_i[7:0] & MODE_MASK[idx];
                  end
               end
               RGN_PULL: begin
                  next_st.rdata[7:0] = st.pu[idx];
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.pu[idx] = wb_dat_i[7:0] & PULL_MASK[idx];
                  end
               end
               default: next_st.rdata = '0;
            endcase
         end else if (rgn == RGN_CTRL) begin
            case (idx)
               IDX_FUNC: begin
                  next_st.rdata[15:0] = st.func;
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.func[7:0] = wb_dat_i[7:0];
                  end
                  if (wb_we_i && wb_sel_i[1]) begin
                     next_st.func[15:8] = {7'h00, wb_dat_i[8]};
                  end
               end
               IDX_ALT: begin
                  next_st.rdata[15:0] = st.alt;
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.alt[7:0] = wb_dat_i[7:0];
                  end
                  if (wb_we_i && wb_sel_i[1]) begin
                     next_st.alt[15:8] = wb_dat_i[15:8];
                  end
               end
               IDX_PCC: begin
                  next_st.rdata[7:0] = st.processor_clock_ctrl;
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.processor_clock_ctrl = wb_dat_i[7:0];
                  end
               end
               IDX_DISP: begin
                  next_st.rdata[4:0] = st.disp;
                  if (wb_we_i && wb_sel_i[0]) begin
                     next_st.disp = wb_dat_i[4:0];
                  end
               end
               default: next_st.rdata = '0;
            endcase
         end
      end

      // Pad drivers, one flop stage from the state
      for (int p = 0; p < NPORT; p++) begin
         for (int b = 0; b < PW; b++) begin
            val = st.dat[p][b];
            drv = PORT_MASK[p][b] & ~dir_in[p][b];
            own = 1'b0;
            if ((p == 2 || p == 3) && st.alt[(p - 2) * PW + b] && drv) begin
               val = alt_val[p - 2][b];
            end
            if (p >= PCH_FIRST && st.disp[p - PCH_FIRST] && PORT_MASK[p][b]) begin
               val = disp_val[p][b];
               drv = 1'b1;
            end
            // Bus lines only pull low so several parties can share them
            own = (p == 2) && (b == 5 || b == 6) && st.func[FN_SBUS] && st.alt[b];
            if (p == NCH_PORT || own) begin
               next_st.pad_out[p][b]  = 1'b0;
               next_st.pad_oe_n[p][b] = ~(drv & ~val);
            end else if (p >= PCH_FIRST) begin
               next_st.pad_out[p][b]  = 1'b1;
               next_st.pad_oe_n[p][b] = ~(drv & val);
            end else begin
               next_st.pad_out[p][b]  = val & drv;
               next_st.pad_oe_n[p][b] = ~drv;
            end
            next_st.pad_pu[p][b] = st.pu[p][b] & PULL_MASK[p][b] & dir_in[p][b]
                                   & ~(p == 1 && st.func[FN_ADC]);
         end
      end

      if (rst_i) begin
         next_st = '0;
         next_st.mode = MODE_MASK;
         next_st.pad_oe_n = '1;
         // Synchronisers keep running so edge detectors see the idle level
         next_st.sync1 = pad_in_i;
         next_st.sync2 = st.sync1;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   // ------------------------------------------------------------
   // Interrupt edges and pin routing
   // ------------------------------------------------------------
   ppm_edge u_irq_a (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (st.sync2[0][0]),
      .mode_i  (st.func[FN_EDGE_A +: 2]),
      .pulse_o (irq_pulse[0])
   );
   ppm_edge u_irq_b (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (st.sync2[0][1]),
      .mode_i  (st.func[FN_EDGE_B +: 2]),
      .pulse_o (irq_pulse[1])
   );
   ppm_edge u_irq_c (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (st.sync2[0][2]),
      .mode_i  (st.func[FN_EDGE_C +: 2]),
      .pulse_o (irq_pulse[2])
   );
   ppm_edge u_irq_d (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .level_i (st.sync2[0][3]),
      .mode_i  (EDGE_FALL),
      .pulse_o (irq_pulse[3])
   );

   assign ext_irq_o                = irq_pulse;
   assign wide_timer_ext_clk_o     = st.sync2[0][0];
   assign narrow_timer_a_ext_clk_o = st.sync2[3][3];
   assign narrow_timer_b_ext_clk_o = st.sync2[3][4];
   // Meaningful only while the pin is left in input mode
   assign updown_count_in_o        = st.sync2[0][3];
   assign ser_b_rx_o               = st.sync2[2][0];
   assign ser_b_clk_in_o           = st.sync2[2][2];
   assign ser_busy_in_o            = st.sync2[2][4];
   assign ser_a_rx_o               = st.sync2[2][5];
   assign ser_bus_line_b_in_o      = st.sync2[2][6];
   assign ser_a_clk_in_o           = st.sync2[2][7];
   assign adc_select_o             = st.func[FN_ADC];
   assign osc_feedback_disable_o   = st.processor_clock_ctrl[PCC_FRC];
   assign pad_out_o                = st.pad_out;
   assign pad_oe_n_o               = st.pad_oe_n;
   assign pad_pu_o                 = st.pad_pu;
   assign wb_dat_o                 = st.rdata;
   assign wb_ack_o                 = st.ack;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_reset_dir: assert property ($past(rst_i) |-> &pad_oe_n_o)
      else $error("pin driven right after reset");
   a_pull_input: assert property (!$past(rst_i) |-> ((pad_pu_o[0] & ~pad_oe_n_o[0]) == '0
      && (pad_pu_o[2] & ~pad_oe_n_o[2]) == '0))
      else $error("pull-up on a driven pin");
   a_pull_analog: assert property (st.func[FN_ADC] |=> pad_pu_o[1] == '0)
      else $error("port one pull-up in analog mode");
   a_irq_a_rise: assert property (st.func[FN_EDGE_A +: 2] == EDGE_RISE
      && $rose(st.sync2[0][0]) ##1 st.func[FN_EDGE_A +: 2] == EDGE_RISE |-> ext_irq_o[0])
      else $error("rising edge missed on first interrupt");
   a_irq_d_fall: assert property ($fell(st.sync2[0][3]) |=> ext_irq_o[3] ##1 !ext_irq_o[3])
      else $error("fourth interrupt not a one-cycle pulse on fall");
   a_irq_d_rise: assert property ($rose(st.sync2[0][3]) |=> !ext_irq_o[3])
      else $error("fourth interrupt fired on rise");
   a_nch_low: assert property (!$past(rst_i) |-> pad_out_o[7] == '0)
      else $error("port seven drives high");
   a_pch_high: assert property (!$past(rst_i) |-> pad_out_o[12:8] == '1)
      else $error("high-voltage port drives low");
   a_strobe_route: assert property (st.alt[3] && !dir_in[2][3]
      |=> pad_out_o[2][3] == $past(auto_xfer_strobe_i))
      else $error("strobe not on its pin");
   a_pwm_select: assert property (st.alt[8] && !dir_in[3][0] && st.func[FN_PWM]
      |=> pad_out_o[3][0] == $past(pwm_out_i))
      else $error("PWM not on timer pin");

   c_irq_both: cover property (st.func[FN_EDGE_A +: 2] == EDGE_BOTH ##1 ext_irq_o[0]);
   c_write: cover property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o);
   c_bus_drive: cover property (st.func[FN_SBUS] && !pad_oe_n_o[2][5]);
   c_display: cover property (st.disp[4] && !pad_oe_n_o[12][0]);
endmodule

`default_nettype wire

// ---- test/port_pin_control_mux_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module port_pin_control_mux_test;
   import ppm_pkg::*;
   typedef logic [NPORT-1:0][PW-1:0] ppm_pins_t;
   logic        clk_i, rst_i, cyc, stb, we, wb_ack_o;
   logic [7:0]  adr;
   logic [31:0] dat, rd, wb_dat_o;
   ppm_pins_t   pin, p_out, p_oen, p_pu, drv, en;
   logic [12:0] per;
   logic [33:0] disp;
   logic [3:0]  irq;
   logic [11:0] ins;
   int          failures, checks_done;

   ppm_board u_board (.out_i(p_out), .oe_n_i(p_oen), .pu_i(p_pu), .drv_i(drv), .en_i(en),
      .pin_o(pin));
   ppm_port_mux #(.ADR_W(8)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_in_i(pin), .pad_out_o(p_out),
      .pad_oe_n_o(p_oen), .pad_pu_o(p_pu), .ser_a_tx_i(per[0]), .ser_a_clk_out_i(per[1]),
      .ser_bus_line_a_i(per[2]), .ser_bus_line_b_i(per[3]), .ser_b_tx_i(per[4]),
      .ser_b_clk_out_i(per[5]), .auto_xfer_strobe_i(per[6]), .wide_timer_out_i(per[7]),
      .pwm_out_i(per[8]), .narrow_timer_a_out_i(per[9]), .narrow_timer_b_out_i(per[10]),
      .prog_clock_out_i(per[11]), .buzzer_out_i(per[12]), .display_drive_outputs_i(disp),
      .ext_irq_o(irq), .wide_timer_ext_clk_o(ins[0]), .narrow_timer_a_ext_clk_o(ins[1]),
      .narrow_timer_b_ext_clk_o(ins[2]), .updown_count_in_o(ins[3]), .ser_a_rx_o(ins[4]),
      .ser_bus_line_b_in_o(ins[5]), .ser_a_clk_in_o(ins[6]), .ser_b_rx_o(ins[7]),
      .ser_b_clk_in_o(ins[8]), .ser_busy_in_o(ins[9]), .adc_select_o(ins[10]),
      .osc_feedback_disable_o(ins[11]));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Single classic cycle; read data taken at the ack edge only
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a;
      we  <= w;
      dat <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         failures++;
         final_report();
      end
   endtask

   task automatic cnt(output int a, output int d);
      a = 0;
      d = 0;
      repeat (10) begin
         @(posedge clk_i);
         a += int'(irq[0] === 1'b1);
         d += int'(irq[3] === 1'b1);
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      logic [7:0] e;
      for (int p = 0; p < NPORT; p++) begin
         if (p > 3 && p < 7) continue;
         e = (p == 0 || p == 7) ? 8'h1F : (p > 7 && p < 11) ? 8'h00 : 8'hFF;
         wb(8'h40 + 8'(4 * p), 1'b0, 32'h0);
         chk(rd, 32'(e), "mode after reset");
         if (e != 8'h00) chk(32'(p_oen[p]), 32'hFF, "released after reset");
      end
      wb(8'h40, 1'b1, 32'h0);
      wb(8'h40, 1'b0, 32'h0);
      chk(rd, 32'h11, "port0 input-only bits");
      wb(8'h40, 1'b1, 32'h1F);
      $display("reset test done");
   endtask

   task automatic t_dir;
      wb(8'h08, 1'b1, 32'h01);
      wb(8'h48, 1'b1, 32'hFE);
      wb(8'h88, 1'b1, 32'hFF);
      wb(8'h84, 1'b1, 32'hFF);
      wt(3);
      chk(32'(p_oen[2]), 32'hFE, "per-bit direction");
      chk(32'(p_out[2][0]), 32'h1, "output latch");
      chk(32'(p_pu[2]), 32'hFE, "pull-up inputs only");
      chk(32'(p_pu[1]), 32'hFF, "port1 pull-ups");
      wb(8'hC0, 1'b1, 32'h100);
      wt(3);
      chk(32'(p_pu[1]), 32'h0, "analog drops pull-ups");
      chk(32'(ins[10]), 32'h1, "analog select");
      $display("direction test done");
   endtask

   task automatic t_irq;
      logic [1:0] md [3];
      int a, d;
      md = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
      en[0] <= 8'h09;
      for (int i = 0; i < 3; i++) begin
         wb(8'hC0, 1'b1, {30'h0, md[i]});
         wt(8);
         drv[0] <= 8'h09;
         cnt(a, d);
         chk(32'(a), 32'(md[i] != EDGE_FALL), "rise pulses");
         chk(32'(d), 32'h0, "irq d on rise");
         chk(32'(ins[0]), 32'h1, "timer clock pin");
         chk(32'(ins[3]), 32'h1, "counter pin");
         drv[0] <= 8'h00;
         cnt(a, d);
         chk(32'(a), 32'(md[i] != EDGE_RISE), "fall pulses");
         chk(32'(d), 32'h1, "irq d on fall");
      end
      $display("interrupt test done");
   endtask

   task automatic t_alt;
      wb(8'h4C, 1'b1, 32'hFE);
      wb(8'hC4, 1'b1, 32'h0108);
      wb(8'hC0, 1'b1, 32'h0);
      per[7] <= 1'b1;
      per[6] <= 1'b1;
      wt(3);
      chk(32'(p_out[3][0]), 32'h1, "timer out");
      chk(32'(p_oen[2][3]), 32'h1, "input pin not taken");
      wb(8'h48, 1'b1, 32'hF6);
      wt(3);
      chk(32'(p_out[2][3]), 32'h1, "strobe out");
      chk(32'(p_oen[2][3]), 32'h0, "strobe drives");
      per[7] <= 1'b0;
      per[8] <= 1'b1;
      wb(8'hC0, 1'b1, 32'h40);
      wt(3);
      chk(32'(p_out[3][0]), 32'h1, "pwm out");
      $display("alternate test done");
   endtask

   task automatic t_od;
      wb(8'h1C, 1'b1, 32'h0);
      wb(8'h5C, 1'b1, 32'h1E);
      wb(8'h2C, 1'b1, 32'h01);
      wb(8'h6C, 1'b1, 32'hFE);
      wt(3);
      chk(32'(p_oen[7][0]), 32'h0, "open-drain low");
      chk(32'(p_oen[11]), 32'hFE, "high-voltage per-bit");
      wb(8'h1C, 1'b1, 32'h01);
      disp <= {8'h3C, 8'h00, 8'h00, 8'hA5, 2'b00};
      wb(8'hCC, 1'b1, 32'h12);
      wt(3);
      chk(32'(p_oen[7][0]), 32'h1, "open-drain release");
      chk(32'(pin[9]), 32'hA5, "display on port9");
      chk(32'(p_oen[9]), 32'h5A, "drive high only");
      chk(32'(pin[12]), 32'h3C, "segments on port12");
      wb(8'hD0, 1'b1, 32'hFFFFFFFF);
      wb(8'hD0, 1'b0, 32'h0);
      chk(rd, 32'h0, "unmapped reads zero");
      wb(8'hC8, 1'b1, 32'h40);
      wt(3);
      chk(32'(ins[11]), 32'h1, "feedback disable");
      $display("open-drain test done");
   endtask

   task automatic t_in;
      wb(8'h48, 1'b1, 32'h9F);
      wb(8'hC4, 1'b1, 32'h0060);
      wb(8'hC0, 1'b1, 32'h80);
      per[2] <= 1'b0;
      per[3] <= 1'b1;
      wt(3);
      chk(32'(p_oen[2][6:5]), 32'h2, "bus line pulls low only");
      chk(32'(p_out[2][6:5]), 32'h0, "bus line never drives high");
      wb(8'h48, 1'b1, 32'hFF);
      en[2] <= 8'hF5;
      en[3] <= 8'h18;
      drv[2] <= 8'hF5;
      drv[3] <= 8'h18;
      wt(4);
      chk(32'(ins[9:4]), 32'h3F, "serial and busy inputs high");
      chk(32'(ins[2:1]), 32'h3, "narrow timer clocks high");
      drv[2] <= 8'h00;
      drv[3] <= 8'h00;
      wt(4);
      chk(32'(ins[9:4]), 32'h0, "serial and busy inputs low");
      chk(32'(ins[2:1]), 32'h0, "narrow timer clocks low");
      $display("input test done");
   endtask

   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, adr, dat} = '0;
      {per, disp, drv, en} = '0;
      failures = 0;
      checks_done = 0;
      wt(8);
      rst_i <= 1'b0;
      t_reset();
      t_dir();
      t_irq();
      t_alt();
      t_od();
      t_in();
      final_report();
   end
endmodule

`default_nettype wire

// ---- test/ppm_board.sv ----
`timescale 1ns/1ps
`default_nettype none

module ppm_board (
   input  wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] out_i,
   input  wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] oe_n_i,
   input  wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pu_i,
   input  wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] drv_i,
   input  wire logic [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] en_i,
   output logic      [ppm_pkg::NPORT-1:0][ppm_pkg::PW-1:0] pin_o
);
   import ppm_pkg::*;
   // ------------------------------------------------------------
   // Wire level: device drive, then board drive, then pull-up
   // ------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         for (int b = 0; b < PW; b++) begin
            if (!oe_n_i[p][b])
               pin_o[p][b] = out_i[p][b];
            else if (en_i[p][b])
               pin_o[p][b] = drv_i[p][b];
            else
               pin_o[p][b] = pu_i[p][b] | ~out_i[p][b];   // Floating: no stale level
         end
      end
   end
endmodule

`default_nettype wire
